/* rtl/smbus_pkg.sv */
// constants, register map and timing figures for the smbus control and status block
// Overview of operation
// - extended hold: setup 11, hold 12; else hold 3
// - standard setup is one clock plus software delay
// - timeout timer reloads scl high, counts scl low
// - bus free after both lines high eleven ticks
// - free timeout acts like a detected stop
// - top control nibble: master, transmit, start, stop
// - start/stop flags mark conditions since last interrupt
// - start write begins master start; stays set
// - stop write ends transfer; stop then start
// - ack bit is sent value or received value
// - every received byte sets the ack request flag
// - unwritten ack at interrupt clear sends nack
// - ack drives sda at once, scl held low
// - nacked address ignores slave events until start
// - lost arbitration flagged, cleared with interrupt flag
// - interrupt at transfer edges, bytes, arbitration loss
// - interrupt flag set stalls bus, scl low
// - matching write address enters slave receiver mode
// - stop leaves slave receiver; data write transmits
// - slave receive interrupt comes before ack cycle
// - master status vectors 1110, 1100 and 1000
// - acked master transmit without new data becomes receiver
package smbus_pkg;

   // register byte addresses
   localparam logic [7:0] REG_CTRL       = 8'h00;
   localparam logic [7:0] REG_DATA       = 8'h04;
   localparam logic [7:0] REG_CFG        = 8'h08;
   localparam logic [7:0] REG_OWN_ADDR   = 8'h0c;

   // control register fields
   localparam int         CTRL_MASTER    = 7;
   localparam int         CTRL_TRANSMIT_DIRECTION_FLAG    = 6;
   localparam int         CTRL_START     = 5;
   localparam int         CTRL_STOP      = 4;
   localparam int         CTRL_ACK_REQUEST_FLAG     = 3;
   localparam int         CTRL_ARBITRATION_LOST_FLAG   = 2;
   localparam int         CTRL_ACK       = 1;
   localparam int         CTRL_SI        = 0;
   localparam int         CTRL_ACK_WE    = 8;

   // configuration register fields
   localparam int         CFG_ENABLE     = 0;
   localparam int         CFG_INHIBIT    = 1;
   localparam int         CFG_EXTENDED_HOLD_ENABLE    = 2;
   localparam int         CFG_SCL_TMO    = 3;
   localparam int         CFG_FREE_TMO   = 4;
   localparam int         CFG_DIV_LSB    = 8;

   // reset values
   localparam logic [7:0] DIV_RESET      = 8'h09;
   localparam logic [6:0] OWN_ADDR_RESET = 7'h00;

   // sda setup and hold, in system clocks
   localparam logic [3:0] SETUP_STD_CLKS = 4'h1;
   localparam logic [3:0] HOLD_STD_CLKS  = 4'h3;
   localparam logic [3:0] SETUP_EXT_CLKS = 4'hb;
   localparam logic [3:0] HOLD_EXT_CLKS  = 4'hc;

   // scl shape and bus free, in smbus clock source ticks
   localparam logic [3:0] LOW_TICKS      = 4'h1;
   localparam logic [3:0] HIGH_TICKS     = 4'h2;
   localparam logic [3:0] FREE_TICKS     = 4'ha;
   localparam logic [3:0] CNT_MAX        = 4'hf;
   localparam logic [3:0] FRAME_BITS     = 4'h8;

   // overflow time software programs into the external timeout timer
   localparam int         SCL_LOW_TIMEOUT_MS = 25;

endpackage

/* rtl/line_sync.sv */
// two flip-flop synchroniser for the bus lines
`timescale 1ns/100ps
module line_sync #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // asynchronous in, synchronous out
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_r;

   // lines idle high, so reset to released
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '1;
         q      <= '1;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule

/* rtl/smbus_control_status.sv */
// smbus master/slave control, status and bit sequencing behind an ahb-lite slave
`timescale 1ns/100ps
module smbus_control_status (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // open-drain bus lines
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   // external timeout timer control
   output logic             timeout_timer_reload,
   output logic             timeout_timer_count
);

   typedef enum logic [4:0] {
      SQ_IDLE = 5'b00001,
      SQ_RUN  = 5'b00010,
      SQ_PREP = 5'b00100,
      SQ_RISE = 5'b01000,
      SQ_COND = 5'b10000
   } seq_t;

   seq_t        seq_r, seq_nxt;
   logic        low_r, low_nxt, cond_r, cond_nxt, ph_clr;
   logic [1:0]  line_q;
   logic        p_scl_r, p_sda_r;
   logic        dp_wr_r, dp_rd_r;
   logic [7:0]  dp_addr_r;
   logic        en_r, inh_r, exth_r, tmo_en_r, fte_r;
   logic [7:0]  div_r, div_cnt_r;
   logic [6:0]  own_r;
   logic        si_r, arb_r, ack_request_flag_r, ack_r, ack_wr_r, data_wr_r;
   logic        start_req_r, stop_req_r, start_seen_r, stop_seen_r;
   logic        master_r, transmit_direction_flag_r, slave_act_r, addr_ph_r, addr_ack_r, bus_busy_r;
   logic        rose_r, stretch_r;
   logic [3:0]  bit_cnt_r, hold_cnt_r, setup_cnt_r, ph_cnt_r, free_cnt_r;
   logic [7:0]  shift_r;

   line_sync #(.WIDTH(2)) u_sync (
      .clk   (hclk),
      .rst_n (hresetn),
      .d     ({scl_i, sda_i}),
      .q     (line_q)
   );

   wire        s_scl     = line_q[1];
   wire        s_sda     = line_q[0];

   // bus decode; reads take one wait state so a write just before is visible
   wire        addr_take = hsel & htrans[1] & hready;
   wire        wr_ctrl   = dp_wr_r & (dp_addr_r == smbus_pkg::REG_CTRL);
   wire        wr_data   = dp_wr_r & (dp_addr_r == smbus_pkg::REG_DATA);
   wire        wr_cfg    = dp_wr_r & (dp_addr_r == smbus_pkg::REG_CFG);
   wire        wr_own    = dp_wr_r & (dp_addr_r == smbus_pkg::REG_OWN_ADDR);
   wire [7:0]  ctrl_rd   = {master_r, transmit_direction_flag_r, start_req_r | start_seen_r,
                            stop_req_r | stop_seen_r, ack_request_flag_r, arb_r, ack_r, si_r};
   wire [31:0] cfg_rd    = {16'h0000, div_r, 3'h0, fte_r, tmo_en_r, exth_r, inh_r, en_r};
   wire [31:0] rd_mux    =
      (dp_addr_r == smbus_pkg::REG_CTRL)     ? {24'h000000, ctrl_rd} :
      (dp_addr_r == smbus_pkg::REG_DATA)     ? {24'h000000, shift_r} :
      (dp_addr_r == smbus_pkg::REG_CFG)      ? cfg_rd :
      (dp_addr_r == smbus_pkg::REG_OWN_ADDR) ? {25'h0000000, own_r} : 32'h00000000;

   // bus events seen through the synchroniser
   wire        eng_gate  = (seq_r == SQ_IDLE) | (seq_r == SQ_RUN);
   wire        scl_fall  = p_scl_r & ~s_scl;
   wire        eng_rise  = en_r & eng_gate & ~p_scl_r & s_scl;
   wire        eng_fall  = en_r & scl_fall & rose_r;
   wire        start_det = en_r & p_scl_r & s_scl & p_sda_r & ~s_sda;
   wire        stop_det  = en_r & p_scl_r & s_scl & ~p_sda_r & s_sda;
   wire        act       = master_r | slave_act_r;
   wire        in_data   = bit_cnt_r < smbus_pkg::FRAME_BITS;
   wire        in_ack    = bit_cnt_r == smbus_pkg::FRAME_BITS;
   wire        tick      = div_cnt_r == div_r;

   wire        last_fall = eng_fall & (bit_cnt_r == smbus_pkg::FRAME_BITS - 4'h1);
   wire        addr_hit  = last_fall & addr_ph_r & ~master_r & ~inh_r &
                           (shift_r[7:1] == own_r) & ~shift_r[0];
   wire        rx_byte   = last_fall & act & ~transmit_direction_flag_r;
   wire        tx_byte   = eng_fall & in_ack & act & transmit_direction_flag_r;
   wire        arb_ev    = eng_rise & act & transmit_direction_flag_r & in_data & shift_r[7] & ~s_sda;
   wire        ph_hi     = tick & s_scl & (ph_cnt_r >= smbus_pkg::HIGH_TICKS - 4'h1);
   wire        ph_lo     = ph_cnt_r >= smbus_pkg::LOW_TICKS;
   wire        start_gen = (seq_r == SQ_COND) & cond_r & ph_hi;
   wire        free_to   = fte_r & bus_busy_r & (free_cnt_r > smbus_pkg::FREE_TICKS);
   wire        si_set    = start_gen | rx_byte | tx_byte | addr_hit | arb_ev |
                           (stop_det & slave_act_r) | free_to;
   wire        si_clr    = wr_ctrl & ~hwdata[smbus_pkg::CTRL_SI];
   wire        ack_wr    = wr_ctrl & hwdata[smbus_pkg::CTRL_ACK_WE];
   wire        ack_eff   = ack_wr ? hwdata[smbus_pkg::CTRL_ACK] : (ack_wr_r & ack_r);
   wire        nack_addr = si_clr & addr_ack_r & ~ack_eff;
   wire        to_rx     = si_clr & master_r & transmit_direction_flag_r & (bit_cnt_r == 4'h0) & ack_r &
                           ~data_wr_r & ~wr_data & ~start_seen_r;

   // setup and hold limits
   wire [3:0]  hold_min  = exth_r ? smbus_pkg::HOLD_EXT_CLKS : smbus_pkg::HOLD_STD_CLKS;
   wire [3:0]  setup_min = exth_r ? smbus_pkg::SETUP_EXT_CLKS : smbus_pkg::SETUP_STD_CLKS;
   // the hold count restarts one clock after the synced fall; skip that stale cycle
   wire        hold_ok   = ~p_scl_r & (hold_cnt_r >= hold_min);
   wire        setup_ok  = setup_cnt_r >= setup_min;
   wire        go_start  = en_r & start_req_r & ~bus_busy_r & ~si_r & ~master_r;
   // no release before the new bit is on sda, else the bit goes out one clock late
   wire        rel_ok    = ~si_r & ~stretch_r & setup_ok & ph_lo & ~s_scl & hold_ok &
                           (sda_nxt == sda_oe);
   wire        cond_go   = (bit_cnt_r == 4'h0) & ~si_r & ~stretch_r & hold_ok & ph_lo &
                           (stop_req_r | start_req_r);

   // sda selection: conditions from the sequencer, bits and ack from the engine
   wire        seq_rel   = (seq_r == SQ_COND) ? ~cond_r : cond_r;
   wire        eng_low   = act & ((in_data & transmit_direction_flag_r & ~shift_r[7]) |
                                  (in_ack & ~transmit_direction_flag_r & ack_wr_r & ack_r));
   wire        sda_upd   = ~s_scl & hold_ok;
   wire        sda_nxt   = ~en_r ? 1'b0 : (~eng_gate ? ~seq_rel :
                                          (sda_upd ? eng_low : sda_oe));
   wire        scl_nxt   = en_r & (((seq_nxt == SQ_RUN) & low_nxt) | (seq_nxt == SQ_PREP) |
                                   (stretch_r & act));

   always_comb begin
      seq_nxt  = seq_r;
      low_nxt  = low_r;
      cond_nxt = cond_r;
      ph_clr   = 1'b0;
      case (seq_r)
         SQ_IDLE: begin
            if (go_start) begin
               seq_nxt  = SQ_COND;
               cond_nxt = 1'b1;
               ph_clr   = 1'b1;
            end
         end
         SQ_COND: begin
            if (ph_hi) begin
               seq_nxt = cond_r ? SQ_RUN : SQ_IDLE;
               low_nxt = 1'b1;
               ph_clr  = 1'b1;
            end
         end
         SQ_RUN: begin
            if (low_r && cond_go) begin
               seq_nxt  = SQ_PREP;
               cond_nxt = ~stop_req_r;
               ph_clr   = 1'b1;
            end else if (low_r && rel_ok) begin
               low_nxt = 1'b0;
               ph_clr  = 1'b1;
            end else if (!low_r && ph_hi) begin
               low_nxt = 1'b1;
               ph_clr  = 1'b1;
            end
         end
         SQ_PREP: begin
            if (setup_ok && ph_lo) begin
               seq_nxt = SQ_RISE;
               ph_clr  = 1'b1;
            end
         end
         SQ_RISE: begin
            if (ph_hi) begin
               seq_nxt = SQ_COND;
               ph_clr  = 1'b1;
            end
         end
         default: seq_nxt = SQ_IDLE;
      endcase
      if (!en_r || arb_ev) begin
         seq_nxt = SQ_IDLE;
      end
   end

   // ahb-lite slave
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr_r   <= 1'b0;
         dp_rd_r   <= 1'b0;
         dp_addr_r <= 8'h00;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         dp_wr_r   <= addr_take & hwrite;
         dp_rd_r   <= addr_take & ~hwrite;
         hreadyout <= ~(addr_take & ~hwrite);
         hresp     <= 1'b0;
         if (addr_take) begin
            dp_addr_r <= haddr[7:0];
         end
         if (dp_rd_r) begin
            hrdata <= rd_mux;
         end
      end
   end

   // configuration
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {fte_r, tmo_en_r, exth_r, inh_r, en_r} <= 5'h00;
         div_r <= smbus_pkg::DIV_RESET;
         own_r <= smbus_pkg::OWN_ADDR_RESET;
      end else begin
         if (wr_cfg) begin
            en_r     <= hwdata[smbus_pkg::CFG_ENABLE];
            inh_r    <= hwdata[smbus_pkg::CFG_INHIBIT];
            exth_r   <= hwdata[smbus_pkg::CFG_EXTENDED_HOLD_ENABLE];
            tmo_en_r <= hwdata[smbus_pkg::CFG_SCL_TMO];
            fte_r    <= hwdata[smbus_pkg::CFG_FREE_TMO];
            div_r    <= hwdata[smbus_pkg::CFG_DIV_LSB +: 8];
         end
         if (wr_own) begin
            own_r <= hwdata[6:0];
         end
      end
   end

   // status flags: a hardware set always beats a software clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {si_r, arb_r, ack_request_flag_r, start_seen_r, stop_seen_r} <= 5'h00;
         {start_req_r, stop_req_r, ack_r, ack_wr_r, data_wr_r} <= 5'h00;
      end else begin
         si_r         <= si_set | (si_r & ~si_clr);
         arb_r        <= arb_ev | (arb_r & ~si_clr);
         ack_request_flag_r      <= rx_byte | addr_hit | (ack_request_flag_r & ~si_clr);
         start_seen_r <= start_det | start_gen | (start_seen_r & ~si_clr);
         stop_seen_r  <= stop_det | free_to | (stop_seen_r & ~si_clr);
         if (wr_ctrl) begin
            start_req_r <= hwdata[smbus_pkg::CTRL_START];
         end
         if (seq_r == SQ_RUN && seq_nxt == SQ_PREP && !cond_nxt) begin
            stop_req_r <= 1'b0;
         end else if (wr_ctrl && master_r) begin
            stop_req_r <= hwdata[smbus_pkg::CTRL_STOP];
         end else if (!master_r) begin
            stop_req_r <= 1'b0;
         end
         if (eng_rise && in_ack && transmit_direction_flag_r && act) begin
            ack_r <= ~s_sda;
         end else if (ack_wr) begin
            ack_r <= hwdata[smbus_pkg::CTRL_ACK];
         end else if (si_clr && ack_request_flag_r && !ack_wr_r) begin
            ack_r <= 1'b0;
         end
         ack_wr_r  <= ack_wr | (ack_wr_r & ~si_set);
         data_wr_r <= wr_data | (data_wr_r & ~si_set);
      end
   end

   // mode state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {master_r, transmit_direction_flag_r, slave_act_r, addr_ph_r, addr_ack_r, bus_busy_r} <= 6'h00;
      end else begin
         if (!en_r || arb_ev || (stop_det && seq_r == SQ_COND)) begin
            master_r <= 1'b0;
         end else if (seq_r == SQ_IDLE && go_start) begin
            master_r <= 1'b1;
         end
         if (!en_r || arb_ev || addr_hit || to_rx || stop_det) begin
            transmit_direction_flag_r <= 1'b0;
         end else if (start_gen || (wr_data && slave_act_r)) begin
            transmit_direction_flag_r <= 1'b1;
         end
         if (!en_r || stop_det || free_to || nack_addr) begin
            slave_act_r <= 1'b0;
         end else if (addr_hit) begin
            slave_act_r <= 1'b1;
         end
         if (!en_r || stop_det || last_fall) begin
            addr_ph_r <= 1'b0;
         end else if (start_det) begin
            addr_ph_r <= ~master_r;
         end
         addr_ack_r <= addr_hit | (addr_ack_r & ~si_clr);
         if (!en_r || stop_det || free_to) begin
            bus_busy_r <= 1'b0;
         end else if (start_det) begin
            bus_busy_r <= 1'b1;
         end
      end
   end

   // bit engine, shared by master and slave
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rose_r    <= 1'b0;
         bit_cnt_r <= 4'h0;
         shift_r   <= 8'h00;
      end else begin
         // a fall counts only after a counted rise, so start edges are skipped
         rose_r <= ~start_det & (eng_rise | (rose_r & ~scl_fall));
         if (start_det) begin
            bit_cnt_r <= 4'h0;
         end else if (eng_fall) begin
            bit_cnt_r <= in_ack ? 4'h0 : bit_cnt_r + 4'h1;
         end
         if (wr_data) begin
            shift_r <= hwdata[7:0];
         end else if (eng_rise && in_data) begin
            shift_r <= {shift_r[6:0], s_sda};
         end
      end
   end

   // sequencer, counters and pins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         seq_r     <= SQ_IDLE;
         {low_r, cond_r, stretch_r, p_scl_r, p_sda_r} <= 5'h03;
         {div_cnt_r, hold_cnt_r, setup_cnt_r} <= 16'h0000;
         {ph_cnt_r, free_cnt_r} <= 8'h00;
      end else begin
         seq_r     <= seq_nxt;
         low_r     <= low_nxt;
         cond_r    <= cond_nxt;
         p_scl_r   <= s_scl;
         p_sda_r   <= s_sda;
         stretch_r <= en_r & (si_set | (stretch_r & (si_r | ~setup_ok)));
         div_cnt_r <= tick ? 8'h00 : div_cnt_r + 8'h01;
         hold_cnt_r <= scl_fall ? 4'h0 :
                       (hold_cnt_r == smbus_pkg::CNT_MAX ? hold_cnt_r : hold_cnt_r + 4'h1);
         setup_cnt_r <= (sda_nxt != sda_oe) ? 4'h0 :
                        (setup_cnt_r == smbus_pkg::CNT_MAX ? setup_cnt_r : setup_cnt_r + 4'h1);
         if (ph_clr) begin
            ph_cnt_r <= 4'h0;
         end else if (tick && (scl_oe || s_scl) && ph_cnt_r != smbus_pkg::CNT_MAX) begin
            ph_cnt_r <= ph_cnt_r + 4'h1;
         end
         if (!(s_sda && s_scl)) begin
            free_cnt_r <= 4'h0;
         end else if (tick && free_cnt_r != smbus_pkg::CNT_MAX) begin
            free_cnt_r <= free_cnt_r + 4'h1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {scl_o, scl_oe, sda_o, sda_oe} <= 4'h0;
         timeout_timer_reload <= 1'b0;
         timeout_timer_count  <= 1'b0;
      end else begin
         scl_o  <= 1'b0;
         sda_o  <= 1'b0;
         scl_oe <= scl_nxt;
         sda_oe <= sda_nxt;
         timeout_timer_reload <= tmo_en_r & s_scl;
         timeout_timer_count  <= tmo_en_r & ~s_scl;
      end
   end

endmodule

/* dv/smbus_control_status_chk.sv */
// port assertions for the smbus control and status block
`timescale 1ns/100ps
module smbus_control_status_chk (
   // clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // register bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // lines and timer
   input wire logic        scl_i,
   input wire logic        scl_oe,
   input wire logic        sda_oe,
   input wire logic        timeout_timer_reload,
   input wire logic        timeout_timer_count
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire rd_take = hsel && htrans[1] && hready && !hwrite;
   wire wr_take = hsel && htrans[1] && hready && hwrite;
   wire unmapped = haddr[7:0] > 8'h0c || haddr[1:0] != 2'h0;
   chk_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
      else $error("read wait wrong");
   chk_write_nowait: assert property (wr_take |=> hreadyout)
      else $error("write stalled");
   chk_unmapped_zero: assert property (rd_take && unmapped |=> ##1 hrdata == 32'h0)
      else $error("unmapped read not zero");
   chk_upper_zero: assert property (rd_take |=> ##1 hrdata[31:16] == 16'h0)
      else $error("upper read bits set");
   chk_resp_okay: assert property (!hresp)
      else $error("error response");
   chk_timer_excl: assert property (!(timeout_timer_reload && timeout_timer_count))
      else $error("timer reload and count together");
   chk_reload_high: assert property ($rose(timeout_timer_reload) |-> $past(scl_i, 3))
      else $error("reload without scl high");
   chk_count_low: assert property ($rose(timeout_timer_count) |-> !$past(scl_i, 3))
      else $error("count without scl low");
   chk_sda_hold: assert property ($changed(sda_oe) && scl_oe |-> $past(scl_oe, 2) && $past(scl_oe, 3))
      else $error("sda moved inside hold");
   chk_scl_setup: assert property ($fell(scl_oe) |-> $stable(sda_oe))
      else $error("scl released with sda change");
   chk_start_order: assert property ($rose(sda_oe) && !scl_oe |=> !scl_oe)
      else $error("start without scl high");
   cover property (rd_take && unmapped);
   cover property ($rose(sda_oe) && !scl_oe);
   cover property ($rose(timeout_timer_count));
endmodule
bind smbus_control_status smbus_control_status_chk u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .scl_i(scl_i), .scl_oe(scl_oe), .sda_oe(sda_oe),
   .timeout_timer_reload(timeout_timer_reload), .timeout_timer_count(timeout_timer_count));

/* dv/smbus_peer_model.sv */
// behavioural far-side slave: acks its address, sends TX_BYTE for each read byte until nacked
`timescale 1ns/100ps
module smbus_peer_model #(
   parameter logic [6:0] PEER_ADDR = 7'h50,
   parameter logic [7:0] TX_BYTE   = 8'h96
) (
   // resolved wires
   input  wire logic scl,
   input  wire logic sda,
   // open-drain pull and observations
   output logic      sda_pull,
   output logic      got_nack,
   output logic      stop_seen
);
   logic [3:0] bitcnt;
   logic [7:0] sh;
   logic       first, tx, match;
   initial begin
      sda_pull = 0; got_nack = 0; stop_seen = 0; bitcnt = 0; first = 0; tx = 0; match = 0;
   end
   always @(negedge sda) if (scl) begin
      bitcnt = 0; first = 1; tx = 0; match = 0; sda_pull = 0; stop_seen = 0;
   end
   always @(posedge sda) if (scl) begin
      stop_seen = 1; first = 0; tx = 0; match = 0;
   end
   always @(posedge scl) begin
      bitcnt = bitcnt + 4'h1;
      if (bitcnt <= 4'h8) sh = {sh[6:0], sda};
      else if (tx) got_nack = sda;
   end
   // released bits float to the pull-up, never to a stale value
   always @(negedge scl) begin
      if (bitcnt == 4'h8) begin
         if (first) match = (sh[7:1] == PEER_ADDR);
         sda_pull = match && !tx;
      end else if (bitcnt == 4'h9) begin
         bitcnt = 0;
         if (first) tx = match && sh[0];
         else if (got_nack) tx = 0;
         first = 0;
         sda_pull = tx && !TX_BYTE[7];
      end else sda_pull = tx && !TX_BYTE[3'(3'd7 - bitcnt[2:0])];
   end
endmodule

/* dv/smbus_control_status_tb_top.sv */
// self-checking bench: register access, timeouts and a master read transfer
`timescale 1ns/100ps
module smbus_control_status_tb_top;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, v;
   logic [1:0]  htrans;
   logic        scl_o, scl_oe, sda_o, sda_oe, reload, count;
   logic        sda_pull, got_nack, stop_seen, tb_scl_low, tb_sda_low;
   int          num_errors = 0;
   int          n_compared = 0;
   wire scl_w = !(scl_oe || tb_scl_low);
   wire sda_w = !(sda_oe || sda_pull || tb_sda_low);
   initial begin
      hclk = 0;
      forever #25 hclk = ~hclk;
   end
   smbus_control_status DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_i(scl_w), .scl_o(scl_o),
      .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
      .timeout_timer_reload(reload), .timeout_timer_count(count));
   smbus_peer_model PEER (.scl(scl_w), .sda(sda_w), .sda_pull(sda_pull),
      .got_nack(got_nack), .stop_seen(stop_seen));
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 0; htrans <= 2'h0; hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      v = hrdata;
   endtask
   task wait_si;
      int k;
      k = 0;
      do begin xfer(smbus_pkg::REG_CTRL, 0, 0); k++; end while (v[0] !== 1'b1 && k < 500);
      chk("si", 32'h1, {31'h0, v[0]});
   endtask
   task tally_and_finish;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge hclk);
      num_errors++;
      tally_and_finish;
   end
   initial begin
      hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0;
      tb_scl_low = 0; tb_sda_low = 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1;
      xfer(smbus_pkg::REG_CFG, 0, 0); chk("cfg reset", 32'h900, v);
      xfer(smbus_pkg::REG_CTRL, 0, 0); chk("ctrl reset", 32'h0, v);
      xfer(8'h10, 0, 0); chk("unmapped", 32'h0, v);
      xfer(smbus_pkg::REG_OWN_ADDR, 1, 32'hffff_ff55);
      xfer(smbus_pkg::REG_OWN_ADDR, 0, 0); chk("own addr", 32'h55, v);
      // divider 3, both timeouts, enabled
      xfer(smbus_pkg::REG_CFG, 1, 32'h319);
      repeat (6) @(posedge hclk);
      chk("reload", 32'h1, {31'h0, reload});
      tb_sda_low <= 1; repeat (8) @(posedge hclk);
      tb_scl_low <= 1; repeat (8) @(posedge hclk);
      chk("count", 32'h1, {31'h0, count});
      tb_sda_low <= 0; repeat (8) @(posedge hclk);
      // lines idle with no stop: only the free timeout can end it
      tb_scl_low <= 0; repeat (30) @(posedge hclk);
      xfer(smbus_pkg::REG_CTRL, 0, 0); chk("early free", 32'h0, {31'h0, v[0]});
      wait_si;
      chk("free stop", 32'h1, {31'h0, v[4]});
      xfer(smbus_pkg::REG_CTRL, 1, 0);
      xfer(smbus_pkg::REG_CTRL, 1, 32'h20);
      wait_si;
      chk("start vec", 32'he1, {24'h0, v[7:0]});
      repeat (20) @(posedge hclk);
      chk("stall", 32'h1, {31'h0, scl_oe});
      xfer(smbus_pkg::REG_DATA, 1, 32'ha1);
      xfer(smbus_pkg::REG_CTRL, 1, 0);
      wait_si;
      chk("addr vec", 32'hc3, {24'h0, v[7:0]});
      xfer(smbus_pkg::REG_CTRL, 1, 0);
      wait_si;
      chk("rx vec", 32'h89, {24'h0, v[7:0] & 8'hfd});
      xfer(smbus_pkg::REG_DATA, 0, 0); chk("rx byte", 32'h96, v);
      xfer(smbus_pkg::REG_CTRL, 1, 32'h10);
      for (int k = 0; k < 3000 && !stop_seen; k++) @(posedge hclk);
      chk("nack", 32'h1, {31'h0, got_nack});
      chk("stop", 32'h1, {31'h0, stop_seen});
      xfer(smbus_pkg::REG_CTRL, 0, 0); chk("stop flag", 32'h10, v & 32'h90);
      tally_and_finish;
   end
endmodule
